// file: pkg/cci_pkg.sv
// Constants for the bus command interpreter of the power stage.
// Assumes one 50 MHz clock and frames already assembled by a bus controller.
package cci_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int CAN_BPS = 250_000;
    localparam int BIT_CYCLES = CLK_HZ / CAN_BPS;
    localparam int QUIET_SHORT_S = 60;
    localparam int QUIET_LONG_S = 600;

    // ------------------------------------------------------------
    // Frame identifiers and lengths
    // ------------------------------------------------------------
    localparam logic [20:0] ID_CMD = 21'h000C03;
    localparam logic [20:0] ID_REPLY = 21'h000C02;
    localparam logic [3:0] DLC_CMD = 4'h2;

    // ------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------
    localparam logic [15:0] CMD_OPERATION = 16'h0000;
    localparam logic [15:0] CMD_VSET = 16'h0020;
    localparam logic [15:0] CMD_ISET = 16'h0030;
    localparam logic [15:0] CMD_DATE = 16'h0086;
    localparam logic [15:0] CMD_SER_LO = 16'h0087;
    localparam logic [15:0] CMD_SER_HI = 16'h0088;
    localparam logic [15:0] CMD_SCALE = 16'h00C0;
    localparam logic [15:0] CMD_STATUS = 16'h00C1;
    localparam logic [15:0] CMD_SETUP = 16'h00C2;
    localparam logic [15:0] CMD_FLOW = 16'h0140;

    // ------------------------------------------------------------
    // Scaling codes (0 unsupported, 4..9 = 0.001..100)
    // ------------------------------------------------------------
    localparam logic [3:0] dc_voltage_scale_code = 4'h5;
    localparam logic [3:0] dc_current_scale_code = 4'h5;
    localparam logic [3:0] ac_input_scale_code = 4'h6;
    localparam logic [3:0] SC_FAN = 4'h7;
    localparam logic [3:0] SC_TEMP = 4'h6;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int ST_MASTER = 0;
    localparam int ST_RAIL = 1;
    localparam int ST_PRIMARY = 2;
    localparam int ST_DLOAD = 4;
    localparam int ST_INIT = 5;
    localparam int ST_NVMERR = 6;
    localparam int SU_BUS = 0;
    localparam int SU_INIT_LSB = 1;
    localparam int SU_POL_LSB = 8;
    localparam int SU_OFF = 10;
    localparam int FLOW_MODE = 0;

    // ------------------------------------------------------------
    // Encodings and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] PRE_OFF = 2'h0;
    localparam logic [1:0] PRE_ON = 2'h1;
    localparam logic [1:0] PRE_PREV = 2'h2;
    localparam logic [1:0] CODE_RESERVED = 2'h3;
    localparam logic [1:0] POL_NOW = 2'h0;
    localparam logic [1:0] POL_1MIN = 2'h1;
    localparam logic [1:0] SETUP_INIT_RST = 2'h1;
    localparam logic OP_RST = 1'b1;
    localparam logic FLOW_RST = 1'b0;

endpackage

// file: src/cci_bit_tick.sv
// Bit-rate enable divider for the 250 kbit/s bus.
// Assumes ref_clk at CLK_HZ; tick is one cycle wide.
`timescale 1ns/1ps
`default_nettype none
module cci_bit_tick
    import cci_pkg::*;
(
    input wire logic ref_clk,
    input wire logic resetn,
    output logic tick
);
    typedef struct packed {
        logic [7:0] cnt;
        logic tick;
    } cci_tick_t;

    cci_tick_t r;
    cci_tick_t n;

    always_comb begin
        n = r;
        n.tick = 1'b0;
        if (r.cnt == 8'(BIT_CYCLES - 1)) begin
            n.cnt = 8'h00;
            n.tick = 1'b1;
        end else begin
            n.cnt = r.cnt + 8'h01;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign tick = r.tick;

    property p_bit_period;
        @(posedge ref_clk) disable iff (!resetn) r.tick |-> ##200 r.tick;
    endproperty
    a_bit_period: assert property (p_bit_period) else $error("bit tick period wrong");
endmodule
`default_nettype wire

// file: src/cci_nvm_timer.sv
// Nonvolatile write scheduler: commits after the chosen quiet time.
// Assumes change is a one-cycle pulse per parameter write.
`timescale 1ns/1ps
`default_nettype none
module cci_nvm_timer
    import cci_pkg::*;
#(
    parameter int SEC_CYCLES = CLK_HZ
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic change,
    input wire logic [1:0] policy,
    input wire logic save_off,
    output logic commit
);
    typedef struct packed {
        logic pending;
        logic [31:0] div;
        logic [9:0] quiet;
        logic commit;
    } cci_nvm_t;

    cci_nvm_t r;
    cci_nvm_t n;
    logic due;

    always_comb begin
        n = r;
        n.commit = 1'b0;
        if (policy == POL_NOW) begin
            due = 1'b1;
        end else if (policy == POL_1MIN) begin
            due = r.quiet >= 10'(QUIET_SHORT_S);
        end else begin
            due = r.quiet >= 10'(QUIET_LONG_S);
        end
        if (change) begin
            // A new change restarts the quiet time and wins over a commit.
            n.pending = 1'b1;
            n.div = 32'h0000_0000;
            n.quiet = 10'h000;
        end else if (r.pending) begin
            if (r.div == 32'(SEC_CYCLES - 1)) begin
                n.div = 32'h0000_0000;
                if (r.quiet != 10'h3FF) begin
                    n.quiet = r.quiet + 10'h001;
                end
            end else begin
                n.div = r.div + 32'h0000_0001;
            end
            if (due) begin
                n.pending = 1'b0;
                n.commit = 1'b1;
            end
        end
        if (save_off) begin
            n.pending = 1'b0;
            n.commit = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign commit = r.commit;

    property p_immediate;
        @(posedge ref_clk) disable iff (!resetn)
            change && policy == POL_NOW && !save_off ##1 !change && !save_off |=> commit;
    endproperty
    a_immediate: assert property (p_immediate) else $error("immediate write missing");

    property p_save_off;
        @(posedge ref_clk) disable iff (!resetn) save_off |=> !commit;
    endproperty
    a_save_off: assert property (p_save_off) else $error("write while saving off");
endmodule
`default_nettype wire

// file: src/cci_top.sv
// Command interpreter: decodes bus frames, holds the setup registers,
// builds read replies and drives the power stage control levels.
// Assumes a bus controller hands over whole frames with a valid/ready pair.
//
// Overview of operation
// - Scaling byte0 low nibble: DC voltage code
// - Scaling byte0 high nibble: DC current code
// - Scaling byte1 low nibble: AC voltage code
// - Scaling byte1 high nibble: fan speed code
// - Scaling byte2 low nibble: temperature code
// - Status bit0 shows parallel master
// - Status bits1,2 show rail and primary good
// - Status bit4 shows dummy load on
// - Status bit5 shows initialisation finished
// - Memory error flags, shuts down, indicator dark
// - Setup bit0 picks bus or local control
// - Setup bits1-2 give power-up operation preset
// - Setup high bits0-1 give write delay policy
// - Setup high bit2 disables nonvolatile saving
// - Flow bit0 picks auto or battery mode
// - Read reply: id 02, echo command, data
// - Operation read returns one byte, length three
// - Extended identifiers at 250 kbit/s only
// - Address from three switches, all on zero
// - Setpoints are unsigned counts of 0.01
// - Same factor for writes and reads
// - Flow mode change acts after restart
`timescale 1ns/1ps
`default_nettype none
module cci_top
    import cci_pkg::*;
#(
    parameter int SEC_CYCLES = CLK_HZ
)
(
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic rx_valid,
    input wire logic [28:0] rx_id,
    input wire logic rx_ext,
    input wire logic [3:0] rx_dlc,
    input wire logic [63:0] rx_data,
    output logic rx_ready,
    output logic tx_valid,
    output logic [28:0] tx_id,
    output logic tx_ext,
    output logic [3:0] tx_dlc,
    output logic [63:0] tx_data,
    input wire logic tx_ready,
    input wire logic [2:0] addr_sw,
    input wire logic restart_req,
    input wire logic st_master,
    input wire logic st_rail_good,
    input wire logic st_primary_good,
    input wire logic st_dummy_load,
    input wire logic st_init_done,
    input wire logic st_nvm_error,
    input wire logic [15:0] knob_voltage,
    input wire logic [15:0] knob_current,
    output logic bus_control,
    output logic operate_on,
    output logic [15:0] charge_voltage_setpoint,
    output logic [15:0] charge_current_setpoint,
    output logic flow_mode_active,
    output logic [1:0] nvm_write_policy,
    output logic nvm_save_disable,
    output logic nvm_write_strobe,
    output logic protect_shutdown,
    output logic indicator_on,
    output logic can_bit_tick
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic op;
        logic saved_op;
        logic bus_ctrl;
        logic [1:0] op_init;
        logic [1:0] nvm_pol;
        logic nvm_off;
        logic flow_sel;
        logic flow_act;
        logic [15:0] vset;
        logic [15:0] iset;
        logic [47:0] date;
        logic [47:0] ser_lo;
        logic [47:0] ser_hi;
        logic [15:0] status;
        logic change;
        logic rx_ready;
        logic tx_valid;
        logic [28:0] tx_id;
        logic [3:0] tx_dlc;
        logic [63:0] tx_data;
        logic run;
        logic [15:0] v_out;
        logic [15:0] i_out;
        logic shutdown;
        logic led;
    } cci_state_t;

    cci_state_t r;
    cci_state_t n;

    logic [7:0] unit_addr;
    logic take;
    logic [15:0] cmd;
    logic [3:0] len;
    logic [47:0] wdat;
    logic [47:0] rval;
    logic nvm_commit;

    // ------------------------------------------------------------
    // Data length of each command, zero when unknown
    // ------------------------------------------------------------
    function automatic logic [3:0] cmd_len(input logic [15:0] c);
        if (c == CMD_OPERATION) begin
            cmd_len = 4'h1;
        end else if (c == CMD_VSET || c == CMD_ISET || c == CMD_STATUS) begin
            cmd_len = 4'h2;
        end else if (c == CMD_SETUP || c == CMD_FLOW) begin
            cmd_len = 4'h2;
        end else if (c == CMD_DATE || c == CMD_SER_LO || c == CMD_SER_HI) begin
            cmd_len = 4'h6;
        end else if (c == CMD_SCALE) begin
            cmd_len = 4'h6;
        end else begin
            cmd_len = 4'h0;
        end
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        n = r;
        n.change = 1'b0;
        unit_addr = {5'h00, ~addr_sw};
        cmd = rx_data[15:0];
        len = cmd_len(cmd);
        wdat = rx_data[63:16];
        take = rx_valid && r.rx_ready && rx_ext && rx_id[28:8] == ID_CMD
            && rx_id[7:0] == unit_addr;

        n.status = 16'h0000;
        n.status[ST_MASTER] = st_master;
        n.status[ST_RAIL] = st_rail_good;
        n.status[ST_PRIMARY] = st_primary_good;
        n.status[ST_DLOAD] = st_dummy_load;
        n.status[ST_INIT] = st_init_done;
        n.status[ST_NVMERR] = st_nvm_error;

        // Read value; counts are stored and returned unchanged.
        if (cmd == CMD_OPERATION) begin
            rval = {47'h0, r.op};
        end else if (cmd == CMD_VSET) begin
            rval = {32'h0, r.vset};
        end else if (cmd == CMD_ISET) begin
            rval = {32'h0, r.iset};
        end else if (cmd == CMD_DATE) begin
            rval = r.date;
        end else if (cmd == CMD_SER_LO) begin
            rval = r.ser_lo;
        end else if (cmd == CMD_SER_HI) begin
            rval = r.ser_hi;
        end else if (cmd == CMD_SCALE) begin
            rval = {24'h0, 4'h0, SC_TEMP, SC_FAN, ac_input_scale_code,
                dc_current_scale_code, dc_voltage_scale_code};
        end else if (cmd == CMD_STATUS) begin
            rval = {32'h0, r.status};
        end else if (cmd == CMD_SETUP) begin
            rval = {32'h0, 5'h00, r.nvm_off, r.nvm_pol, 5'h00, r.op_init, r.bus_ctrl};
        end else if (cmd == CMD_FLOW) begin
            rval = {47'h0, r.flow_sel};
        end else begin
            rval = 48'h0;
        end

        if (r.tx_valid && tx_ready) begin
            n.tx_valid = 1'b0;
        end

        if (take && len != 4'h0) begin
            if (rx_dlc == DLC_CMD) begin
                n.tx_valid = 1'b1;
                n.tx_id = {ID_REPLY, unit_addr};
                n.tx_dlc = DLC_CMD + len;
                n.tx_data = {rval, cmd};
            end else if (rx_dlc == DLC_CMD + len) begin
                if (cmd == CMD_OPERATION) begin
                    n.op = wdat[0];
                    n.change = 1'b1;
                end else if (cmd == CMD_VSET) begin
                    n.vset = wdat[15:0];
                    n.change = 1'b1;
                end else if (cmd == CMD_ISET) begin
                    n.iset = wdat[15:0];
                    n.change = 1'b1;
                end else if (cmd == CMD_DATE) begin
                    n.date = wdat;
                end else if (cmd == CMD_SER_LO) begin
                    n.ser_lo = wdat;
                end else if (cmd == CMD_SER_HI) begin
                    n.ser_hi = wdat;
                end else if (cmd == CMD_SETUP) begin
                    n.bus_ctrl = wdat[SU_BUS];
                    if (wdat[SU_INIT_LSB +: 2] != CODE_RESERVED) begin
                        n.op_init = wdat[SU_INIT_LSB +: 2];
                    end
                    if (wdat[SU_POL_LSB +: 2] != CODE_RESERVED) begin
                        n.nvm_pol = wdat[SU_POL_LSB +: 2];
                    end
                    n.nvm_off = wdat[SU_OFF];
                end else if (cmd == CMD_FLOW) begin
                    n.flow_sel = wdat[FLOW_MODE];
                end
            end
        end

        if (nvm_commit) begin
            n.saved_op = r.op;
        end

        // A restart applies the power-up preset and the stored flow mode.
        if (restart_req) begin
            n.flow_act = r.flow_sel;
            if (r.op_init == PRE_OFF) begin
                n.op = 1'b0;
            end else if (r.op_init == PRE_ON) begin
                n.op = 1'b1;
            end else if (r.op_init == PRE_PREV) begin
                n.op = r.saved_op;
            end
        end

        n.run = (r.bus_ctrl ? r.op : 1'b1) && !st_nvm_error;
        n.v_out = r.bus_ctrl ? r.vset : knob_voltage;
        n.i_out = r.bus_ctrl ? r.iset : knob_current;
        n.shutdown = st_nvm_error;
        n.led = !st_nvm_error;
        n.rx_ready = !n.tx_valid;
    end

    always_ff @(posedge ref_clk) begin
        if (!resetn) begin
            r <= '0;
            r.op <= OP_RST;
            r.saved_op <= OP_RST;
            r.op_init <= SETUP_INIT_RST;
            r.nvm_pol <= POL_NOW;
            r.flow_sel <= FLOW_RST;
            r.flow_act <= FLOW_RST;
            r.rx_ready <= 1'b1;
            r.led <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    cci_nvm_timer #(
        .SEC_CYCLES(SEC_CYCLES)
    ) u_nvm (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .change(r.change),
        .policy(r.nvm_pol),
        .save_off(r.nvm_off),
        .commit(nvm_commit)
    );

    cci_bit_tick u_tick (
        .ref_clk(ref_clk),
        .resetn(resetn),
        .tick(can_bit_tick)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign rx_ready = r.rx_ready;
    assign tx_valid = r.tx_valid;
    assign tx_id = r.tx_id;
    assign tx_ext = 1'b1;
    assign tx_dlc = r.tx_dlc;
    assign tx_data = r.tx_data;
    assign bus_control = r.bus_ctrl;
    assign operate_on = r.run;
    assign charge_voltage_setpoint = r.v_out;
    assign charge_current_setpoint = r.i_out;
    assign flow_mode_active = r.flow_act;
    assign nvm_write_policy = r.nvm_pol;
    assign nvm_save_disable = r.nvm_off;
    assign nvm_write_strobe = nvm_commit;
    assign protect_shutdown = r.shutdown;
    assign indicator_on = r.led;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_op_reply;
        @(posedge ref_clk) disable iff (!resetn)
            take && rx_dlc == 4'h2 && rx_data[15:0] == 16'h0000 |=>
            tx_valid && tx_dlc == 4'h3 && tx_id[28:8] == 21'h000C02
            && tx_data[15:0] == 16'h0000 && tx_data[23:16] == {7'h00, $past(r.op)};
    endproperty
    a_op_reply: assert property (p_op_reply) else $error("operation reply wrong");

    property p_reply_addr;
        @(posedge ref_clk) disable iff (!resetn)
            take && rx_dlc == 4'h2 && len != 4'h0 |=> tx_id[7:0] == $past(rx_id[7:0]);
    endproperty
    a_reply_addr: assert property (p_reply_addr) else $error("reply address wrong");

    property p_std_ignored;
        @(posedge ref_clk) disable iff (!resetn)
            !tx_valid && rx_valid && !rx_ext |=> !tx_valid;
    endproperty
    a_std_ignored: assert property (p_std_ignored) else $error("standard frame answered");

    property p_scale;
        @(posedge ref_clk) disable iff (!resetn)
            take && rx_dlc == 4'h2 && rx_data[15:0] == 16'h00C0 |=>
            tx_data[39:16] == 24'h067655 && tx_dlc == 4'h8;
    endproperty
    a_scale: assert property (p_scale) else $error("scaling reply wrong");

    property p_nvm_err;
        @(posedge ref_clk) disable iff (!resetn)
            st_nvm_error |=> !operate_on && !indicator_on && protect_shutdown;
    endproperty
    a_nvm_err: assert property (p_nvm_err) else $error("memory error not shut down");

    property p_reserved;
        @(posedge ref_clk) disable iff (!resetn)
            take && rx_dlc == 4'h4 && rx_data[15:0] == 16'h00C2
            && rx_data[18:17] == 2'h3 && !restart_req |=> $stable(r.op_init);
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved preset taken");

    property p_flow_delay;
        @(posedge ref_clk) disable iff (!resetn)
            !restart_req |=> $stable(flow_mode_active);
    endproperty
    a_flow_delay: assert property (p_flow_delay) else $error("flow mode changed early");

    property p_local;
        @(posedge ref_clk) disable iff (!resetn)
            !bus_control ##1 !bus_control |-> charge_voltage_setpoint == $past(knob_voltage);
    endproperty
    a_local: assert property (p_local) else $error("local setpoint not followed");
endmodule
`default_nettype wire

// file: test/can_command_register_interface_bench.sv
// Self-checking bench for the command interpreter.
// Assumes cci_top, cci_pkg and the controller model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module can_command_register_interface_bench import cci_pkg::*;;
    logic ref_clk, resetn, rx_valid, rx_ext, rx_ready, tx_valid, tx_ext, tx_ready, restart_req;
    logic [28:0] rx_id, tx_id, rid;
    logic [3:0] rx_dlc, tx_dlc, rdlc;
    logic [63:0] rx_data, tx_data, rdata, w;
    logic [2:0] addr_sw;
    logic [5:0] st;
    logic [7:0] addr;
    logic [15:0] knob_voltage, knob_current, charge_voltage_setpoint, charge_current_setpoint, v;
    logic bus_control, operate_on, flow_mode_active, nvm_save_disable, nvm_write_strobe;
    logic protect_shutdown, indicator_on, can_bit_tick, ext_sel;
    logic [1:0] nvm_write_policy;
    int errors, compares, seed, ticks, strobes;

    cci_top #(.SEC_CYCLES(10)) uut (.ref_clk, .resetn, .rx_valid, .rx_id, .rx_ext, .rx_dlc,
        .rx_data, .rx_ready, .tx_valid, .tx_id, .tx_ext, .tx_dlc, .tx_data, .tx_ready,
        .addr_sw, .restart_req, .st_master(st[0]), .st_rail_good(st[1]),
        .st_primary_good(st[2]), .st_dummy_load(st[3]), .st_init_done(st[4]),
        .st_nvm_error(st[5]), .knob_voltage, .knob_current, .bus_control, .operate_on,
        .charge_voltage_setpoint, .charge_current_setpoint, .flow_mode_active,
        .nvm_write_policy, .nvm_save_disable, .nvm_write_strobe, .protect_shutdown,
        .indicator_on, .can_bit_tick);
    cci_ctrl_model ctl (.ref_clk, .rx_ready, .tx_valid, .tx_id, .tx_dlc, .tx_data, .rx_valid,
        .rx_id, .rx_ext, .rx_dlc, .rx_data, .tx_ready, .ext_sel);

    // ------------------------------------------------------------
    // Clock, counters and helpers
    // ------------------------------------------------------------
    initial ref_clk = 1'b0;
    always #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (can_bit_tick === 1'b1) ticks++;
        if (nvm_write_strobe === 1'b1) strobes++;
    end

    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish;
        if (errors == 0 && compares > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic wr(input logic [3:0] dlc, input logic [63:0] d);
        ctl.send({ID_CMD, addr}, dlc, d);
    endtask

    task automatic rd(input logic [15:0] cmd);
        ctl.fetch({ID_CMD, addr}, cmd, $unsigned($random(seed)) % 4, rid, rdlc, rdata);
    endtask

    function automatic logic [63:0] r16(input logic [15:0] cmd, input logic [15:0] val);
        return {32'h0, val, cmd};
    endfunction

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        #1_000_000;
        errors++;
        tally_and_finish();
    end

    initial begin
        seed = 46118;
        errors = 0;
        compares = 0;
        resetn = 1'b0;
        restart_req = 1'b0;
        st = 6'h00;
        knob_voltage = 16'($random(seed));
        knob_current = 16'($random(seed));
        addr_sw = 3'($random(seed));
        addr = {5'h00, ~addr_sw};
        ext_sel = 1'b1;
        repeat (6) @(negedge ref_clk);
        resetn = 1'b1;
        rd(CMD_SCALE);
        chk(64'(rid), {35'h0, ID_REPLY, addr});
        chk(64'(rdlc), 64'h8);
        chk(64'(tx_ext), 64'h1);
        chk(rdata, {28'h0, SC_TEMP, SC_FAN, ac_input_scale_code, dc_current_scale_code,
            dc_voltage_scale_code, CMD_SCALE});
        chk({32'h0, charge_voltage_setpoint, charge_current_setpoint},
            {32'h0, knob_voltage, knob_current});
        for (int i = 0; i < 4; i++) begin
            st = (i == 0) ? 6'h1F : 6'($random(seed));
            rd(CMD_STATUS);
            chk(rdata, r16(CMD_STATUS, {9'h0, st[5:3], 1'b0, st[2:0]}));
        end
        st = 6'h20;
        repeat (3) @(negedge ref_clk);
        chk(64'({protect_shutdown, indicator_on, operate_on}), 64'h4);
        st = 6'h00;
        repeat (3) @(negedge ref_clk);
        chk(64'({protect_shutdown, indicator_on, operate_on}), 64'h3);
        wr(4'h4, r16(CMD_SETUP, 16'h0003));
        chk(64'(bus_control), 64'h1);
        v = 16'($random(seed));
        strobes = 0;
        wr(4'h4, r16(CMD_VSET, v));
        repeat (6) @(negedge ref_clk);
        chk({48'h0, charge_voltage_setpoint}, {48'h0, v});
        chk(64'(strobes), 64'h1);
        rd(CMD_VSET);
        chk(rdata, r16(CMD_VSET, v));
        wr(4'h4, r16(CMD_SETUP, 16'h0403));
        strobes = 0;
        wr(4'h4, r16(CMD_ISET, ~v));
        repeat (20) @(negedge ref_clk);
        chk(64'({nvm_save_disable, strobes[0]}), 64'h2);
        chk({48'h0, charge_current_setpoint}, {48'h0, ~v});
        wr(4'h4, r16(CMD_SETUP, 16'h0307));
        rd(CMD_SETUP);
        chk(rdata, r16(CMD_SETUP, 16'h0003));
        wr(4'h4, r16(CMD_SETUP, 16'h0105));
        rd(CMD_SETUP);
        chk(rdata, r16(CMD_SETUP, 16'h0105));
        chk(64'(nvm_write_policy), 64'(POL_1MIN));
        rd(CMD_OPERATION);
        chk({rdata[59:0], rdlc}, {36'h0, 8'h01, CMD_OPERATION, 4'h3});
        wr(4'h3, {40'h0, 8'h00, CMD_OPERATION});
        repeat (3) @(negedge ref_clk);
        chk(64'(operate_on), 64'h0);
        wr(4'h4, r16(CMD_FLOW, 16'h0001));
        repeat (3) @(negedge ref_clk);
        chk(64'(flow_mode_active), 64'h0);
        restart_req = 1'b1;
        @(negedge ref_clk);
        restart_req = 1'b0;
        repeat (2) @(negedge ref_clk);
        chk(64'(flow_mode_active), 64'h1);
        chk(64'(operate_on), 64'h1);
        ctl.send({ID_CMD, addr ^ 8'h01}, 4'h2, {48'h0, CMD_OPERATION});
        repeat (4) @(negedge ref_clk);
        chk(64'(tx_valid), 64'h0);
        ext_sel = 1'b0;
        ctl.send({ID_CMD, addr}, 4'h2, {48'h0, CMD_OPERATION});
        ext_sel = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk(64'(tx_valid), 64'h0);
        addr_sw = 3'h7;
        addr = 8'h00;
        rd(CMD_FLOW);
        chk(64'(rid), {35'h0, ID_REPLY, 8'h00});
        chk(rdata, r16(CMD_FLOW, 16'h0001));
        for (int i = 0; i < 3; i++) begin
            w = {16'($random(seed)), 32'($random(seed)), CMD_DATE + 16'(i)};
            wr(4'h8, w);
            rd(w[15:0]);
            chk(rdata, w);
        end
        ticks = 0;
        repeat (400) @(negedge ref_clk);
        chk(64'(ticks), 64'h2);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// file: test/cci_ctrl_model.sv
// Remote bus controller model: offers whole frames and collects replies.
// Assumes the interpreter's valid/ready frame port and a free-running ref_clk.
`timescale 1ns/1ps
`default_nettype none
module cci_ctrl_model (
    input wire logic ref_clk,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [28:0] tx_id,
    input wire logic [3:0] tx_dlc,
    input wire logic [63:0] tx_data,
    input wire logic ext_sel,
    output logic rx_valid,
    output logic [28:0] rx_id,
    output logic rx_ext,
    output logic [3:0] rx_dlc,
    output logic [63:0] rx_data,
    output logic tx_ready
);
    initial begin
        rx_valid = 1'b0;
        rx_id = '0;
        rx_ext = 1'b1;
        rx_dlc = '0;
        rx_data = '0;
        tx_ready = 1'b0;
    end

    // Idle id, length and data fields show the inverse of the last frame; rx_ext keeps its last value.
    task automatic send(input logic [28:0] id, input logic [3:0] dlc, input logic [63:0] d);
        int n;
        @(negedge ref_clk);
        rx_valid = 1'b1;
        rx_ext = ext_sel;
        rx_id = id;
        rx_dlc = dlc;
        rx_data = d;
        n = 0;
        while (rx_ready !== 1'b1 && n < 50) begin
            @(negedge ref_clk);
            n++;
        end
        @(negedge ref_clk);
        rx_valid = 1'b0;
        rx_id = ~id;
        rx_dlc = ~dlc;
        rx_data = ~d;
    endtask

    // A read sends the command code alone and may stall before taking the reply.
    task automatic fetch(input logic [28:0] id, input logic [15:0] cmd, input int stall,
        output logic [28:0] rid, output logic [3:0] rdlc, output logic [63:0] rdata);
        int n;
        send(id, 4'h2, {48'h0, cmd});
        n = 0;
        while (tx_valid !== 1'b1 && n < 20) begin
            @(negedge ref_clk);
            n++;
        end
        repeat (stall) @(negedge ref_clk);
        rid = tx_id;
        rdlc = tx_dlc;
        rdata = tx_data;
        tx_ready = 1'b1;
        @(negedge ref_clk);
        tx_ready = 1'b0;
    endtask
endmodule
`default_nettype wire
